// ### pkg/l1a_pkg.sv
// Constants, codes, register map and types of the layer-1 activation block
package l1a_pkg;
    // ****************************************
    // Host command codes
    // ****************************************
    localparam logic [3:0] CLOCK_REQUEST_CMD = 4'h0;
    localparam logic [3:0] FSM_REINIT_CMD = 4'h1;
    localparam logic [3:0] SINGLE_PULSE_CMD = 4'h2;
    localparam logic [3:0] CONTINUOUS_PULSE_CMD = 4'h3;
    localparam logic [3:0] ACTIVATE_REQUEST_CODE = 4'h8;
    localparam logic [3:0] LOCAL_LOOP_REQUEST_CODE = 4'h9;
    localparam logic [3:0] DEACTIVATE_CMD = 4'hf;
    // ****************************************
    // Host indication codes
    // ****************************************
    localparam logic [3:0] DEACT_REQUEST_IND = 4'h0;
    localparam logic [3:0] POWERED_UP_IND = 4'h7;
    localparam logic [3:0] TEST_MODE_ACK_IND = 4'h2;
    localparam logic [3:0] RECEIVER_UNSYNC_IND = 4'h4;
    localparam logic [3:0] REMOTE_LOOP_SYNC_IND = 4'ha;
    localparam logic [3:0] ACTIVE_IND = 4'hc;
    localparam logic [3:0] LOCAL_LOOP_ACTIVE_IND = 4'hd;
    localparam logic [3:0] REMOTE_LOOP_ACTIVE_IND = 4'he;
    localparam logic [3:0] DEACTIVATION_CONFIRM_IND = 4'hf;
    // ****************************************
    // Line infos
    // ****************************************
    localparam logic [1:0] RX_I0 = 2'h0;
    localparam logic [1:0] RX_I2 = 2'h1;
    localparam logic [1:0] RX_I4 = 2'h2;
    localparam logic [1:0] RX_IX = 2'h3;
    localparam logic [2:0] TX_I0 = 3'h0;
    localparam logic [2:0] TX_I1W = 3'h1;
    localparam logic [2:0] TX_I1 = 3'h2;
    localparam logic [2:0] TX_I3 = 3'h3;
    localparam logic [2:0] TX_IT1 = 3'h4;
    localparam logic [2:0] TX_IT2 = 3'h5;
    // ****************************************
    // Register map
    // ****************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_CONF = 8'h00;
    localparam logic [7:0] REG_SW_CLEAR = 8'h04;
    localparam logic [7:0] REG_LINE_TX_CMD = 8'h08;
    localparam logic [7:0] REG_LINE_RX_STA = 8'h0c;
    localparam logic [7:0] REG_FSM_STA = 8'h10;
    localparam int CONF_SW_SEL_BIT = 0;
    localparam int CONF_CKS_BIT = 1;
    localparam int CONF_IRQ_MASK_BIT = 2;
    localparam int SW_CLEAR_BIT = 0;
    localparam logic [2:0] CONF_RESET = 3'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [7:0] B_IDLE = 8'hff;
    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [10:0] {
        ST_RST_PEND = 11'h001,
        ST_DEACT = 11'h002,
        ST_PWRUP = 11'h004,
        ST_PEND_ACT = 11'h008,
        ST_LVL_DET = 11'h010,
        ST_SYNCD = 11'h020,
        ST_ACTV = 11'h040,
        ST_LP_PEND = 11'h080,
        ST_LP_SYNC = 11'h100,
        ST_LP_ACT = 11'h200,
        ST_TEST = 11'h400
    } l1a_state_t;
    typedef struct packed {
        logic level;
        logic sbit;
        logic sync;
        logic [1:0] info;
    } l1a_rxsta_t;
endpackage

// ### core/l1a_core.sv
// Layer-1 activation state machine with AXI4-Lite register slave
//
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module l1a_core
    import l1a_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic rst_pin_n,
    input wire logic frame_tick,
    input wire logic [3:0] host_cmd,
    input wire l1a_rxsta_t rx_sta,
    input wire logic [7:0] b_line_data,
    output logic [3:0] host_ind,
    output logic [2:0] tx_info,
    output logic loop_en,
    output logic host_power_down,
    output logic [7:0] b_host_data,
    output logic rx_status_change_irq,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ****************************************
    // Reset pin synchroniser
    // ****************************************
    logic pin_s1_r;
    logic pin_s2_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1_r <= 1'b1;
            pin_s2_r <= 1'b1;
        end else begin
            pin_s1_r <= rst_pin_n;
            pin_s2_r <= pin_s1_r;
        end
    end

    // ****************************************
    // AXI4-Lite write path
    // ****************************************
    logic aw_held_r;
    logic w_held_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    wire aw_take = s_axi_awvalid && !aw_held_r && !bvalid_r;
    wire w_take = s_axi_wvalid && !w_held_r && !bvalid_r;
    wire wr_fire = aw_held_r && w_held_r && !bvalid_r;
    wire [7:0] wr_off = awaddr_r & 8'hfc;
    wire wr_conf = wr_fire && (wr_off == REG_CONF);
    wire wr_clear = wr_fire && (wr_off == REG_SW_CLEAR);
    wire wr_txcmd = wr_fire && (wr_off == REG_LINE_TX_CMD);
    wire wr_known = wr_off == REG_CONF || wr_off == REG_SW_CLEAR ||
                    wr_off == REG_LINE_TX_CMD || wr_off == REG_LINE_RX_STA ||
                    wr_off == REG_FSM_STA;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_held_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (w_take) begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end
    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready = !w_held_r && !bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    // ****************************************
    // Software registers
    // ****************************************
    logic [2:0] conf_r;
    logic [2:0] line_tx_command_reg;
    logic sw_clear_r;
    wire byte0 = wstrb_r[0];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conf_r <= CONF_RESET;
            line_tx_command_reg <= TX_I0;
            sw_clear_r <= 1'b0;
        end else begin
            if (wr_conf && byte0) begin
                conf_r <= wdata_r[2:0];
            end
            if (wr_txcmd && byte0) begin
                line_tx_command_reg <= wdata_r[2:0];
            end
            // Self-clearing, seen as one pulse by the machine
            sw_clear_r <= wr_clear && byte0 && wdata_r[SW_CLEAR_BIT];
        end
    end
    wire software_layer1_select = conf_r[CONF_SW_SEL_BIT];
    wire power_down_clock_stop = conf_r[CONF_CKS_BIT];
    wire irq_mask = conf_r[CONF_IRQ_MASK_BIT];
    // ****************************************
    // Receive status and change flag
    // ****************************************
    logic [4:0] rx_prev_r;
    logic chg_flag_r;
    logic rd_sta_clr;
    wire rx_changed = rx_sta != rx_prev_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_prev_r <= '0;
            chg_flag_r <= 1'b0;
        end else begin
            rx_prev_r <= rx_sta;
            // A change in the read cycle keeps the flag set
            if (rx_changed) begin
                chg_flag_r <= 1'b1;
            end else if (rd_sta_clr) begin
                chg_flag_r <= 1'b0;
            end
        end
    end
    // ****************************************
    // Command decode and receive classes
    // ****************************************
    wire cmd_clk = host_cmd == CLOCK_REQUEST_CMD;
    wire cmd_rst = host_cmd == FSM_REINIT_CMD;
    wire cmd_pl1 = host_cmd == SINGLE_PULSE_CMD;
    wire cmd_plc = host_cmd == CONTINUOUS_PULSE_CMD;
    wire cmd_up = host_cmd == ACTIVATE_REQUEST_CODE;
    wire cmd_lpb = host_cmd == LOCAL_LOOP_REQUEST_CODE;
    wire cmd_dn = host_cmd == DEACTIVATE_CMD;
    wire rx_i0 = rx_sta.info == RX_I0;
    wire rx_i2 = rx_sta.sync && rx_sta.info == RX_I2;
    wire rx_i4 = rx_sta.sync && rx_sta.info == RX_I4;
    wire rx_lost = !rx_sta.sync;
    wire restart = cmd_rst || sw_clear_r || !pin_s2_r;
    // ****************************************
    // State machine
    // ****************************************
    l1a_state_t state_r;
    l1a_state_t state_nxt;
    logic test_cont_r;
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_RST_PEND: begin
                if (cmd_dn) state_nxt = ST_DEACT;
            end
            ST_DEACT, ST_PWRUP: begin
                if (cmd_up) state_nxt = ST_PEND_ACT;
                else if (cmd_lpb) state_nxt = ST_LP_PEND;
                else if (!rx_i0) state_nxt = ST_LVL_DET;
                else if (cmd_clk) state_nxt = ST_PWRUP;
            end
            ST_PEND_ACT: begin
                if (!rx_i0) state_nxt = ST_LVL_DET;
            end
            ST_LVL_DET: begin
                if (rx_i0) state_nxt = ST_RST_PEND;
                else if (rx_i4) state_nxt = ST_ACTV;
                else if (rx_i2) state_nxt = ST_SYNCD;
            end
            ST_SYNCD, ST_ACTV: begin
                if (rx_i0) state_nxt = ST_RST_PEND;
                else if (rx_lost) state_nxt = ST_LVL_DET;
                else if (rx_i4) state_nxt = ST_ACTV;
                else if (rx_i2) state_nxt = ST_SYNCD;
            end
            ST_LP_PEND: begin
                if (!rx_lost) state_nxt = ST_LP_SYNC;
            end
            ST_LP_SYNC: begin
                if (rx_i4) state_nxt = ST_LP_ACT;
            end
            ST_LP_ACT: begin
                if (rx_lost) state_nxt = ST_LP_PEND;
            end
            ST_TEST: begin
                state_nxt = ST_TEST;
            end
        endcase
        // Commands that override the line events
        if ((cmd_pl1 || cmd_plc) && state_r != ST_RST_PEND) begin
            state_nxt = ST_TEST;
        end
        if (cmd_dn && state_r != ST_DEACT) begin
            state_nxt = ST_DEACT;
        end
    end

    // Software mode freezes the internal machine
    wire step = frame_tick && !software_layer1_select;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= ST_RST_PEND;
            test_cont_r <= 1'b0;
        end else begin
            if (restart && !software_layer1_select) begin
                state_r <= ST_RST_PEND;
            end else if (step) begin
                state_r <= state_nxt;
                if (cmd_plc) test_cont_r <= 1'b1;
                else if (cmd_pl1) test_cont_r <= 1'b0;
            end
        end
    end
    // ****************************************
    // Per-state outputs
    // ****************************************
    logic [2:0] fsm_tx;
    logic [3:0] fsm_ind;
    always_comb begin
        fsm_tx = TX_I0;
        fsm_ind = DEACT_REQUEST_IND;
        unique case (state_r)
            ST_RST_PEND: begin
                fsm_tx = TX_I0;
                fsm_ind = DEACT_REQUEST_IND;
            end
            ST_DEACT: begin
                fsm_tx = TX_I0;
                fsm_ind = DEACTIVATION_CONFIRM_IND;
            end
            ST_PWRUP: begin
                fsm_tx = TX_I0;
                fsm_ind = POWERED_UP_IND;
            end
            ST_PEND_ACT: begin
                fsm_tx = TX_I1W;
                fsm_ind = POWERED_UP_IND;
            end
            ST_LVL_DET: begin
                fsm_tx = TX_I0;
                fsm_ind = RECEIVER_UNSYNC_IND;
            end
            ST_SYNCD: begin
                fsm_tx = TX_I1;
                fsm_ind = rx_sta.sbit ? REMOTE_LOOP_SYNC_IND : ACTIVATE_REQUEST_CODE;
            end
            ST_ACTV: begin
                fsm_tx = TX_I3;
                fsm_ind = rx_sta.sbit ? REMOTE_LOOP_ACTIVE_IND : ACTIVE_IND;
            end
            ST_LP_PEND: begin
                fsm_tx = TX_I1;
                fsm_ind = RECEIVER_UNSYNC_IND;
            end
            ST_LP_SYNC: begin
                fsm_tx = TX_I3;
                fsm_ind = LOCAL_LOOP_REQUEST_CODE;
            end
            ST_LP_ACT: begin
                fsm_tx = TX_I3;
                fsm_ind = LOCAL_LOOP_ACTIVE_IND;
            end
            ST_TEST: begin
                fsm_tx = test_cont_r ? TX_IT1 : TX_IT2;
                fsm_ind = TEST_MODE_ACK_IND;
            end
        endcase
    end

    wire in_loop = state_r == ST_LP_PEND || state_r == ST_LP_SYNC || state_r == ST_LP_ACT;
    wire pass_b = state_r == ST_ACTV && !software_layer1_select;

    // ****************************************
    // Registered outputs
    // ****************************************
    logic [3:0] ind_r;
    logic [2:0] tx_r;
    logic loop_r;
    logic pd_r;
    logic [7:0] b_r;
    logic irq_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ind_r <= DEACT_REQUEST_IND;
            tx_r <= TX_I0;
            loop_r <= 1'b0;
            pd_r <= 1'b0;
            b_r <= B_IDLE;
            irq_r <= 1'b0;
        end else begin
            if (frame_tick) begin
                ind_r <= fsm_ind;
            end
            tx_r <= software_layer1_select ? line_tx_command_reg : fsm_tx;
            loop_r <= in_loop && !software_layer1_select;
            pd_r <= state_r == ST_DEACT && power_down_clock_stop;
            b_r <= pass_b ? b_line_data : B_IDLE;
            irq_r <= chg_flag_r && !irq_mask;
        end
    end
    assign host_ind = ind_r;
    assign tx_info = tx_r;
    assign loop_en = loop_r;
    assign host_power_down = pd_r;
    assign b_host_data = b_r;
    assign rx_status_change_irq = irq_r;

    // ****************************************
    // AXI4-Lite read path
    // ****************************************
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic [31:0] rd_mux;
    logic rd_ok;
    wire ar_take = s_axi_arvalid && !rvalid_r;
    wire [7:0] rd_off = s_axi_araddr & 8'hfc;
    always_comb begin
        rd_mux = '0;
        rd_ok = 1'b1;
        unique case (rd_off)
            REG_CONF: rd_mux = {29'h0, conf_r};
            REG_SW_CLEAR: rd_mux = '0;
            REG_LINE_TX_CMD: rd_mux = {29'h0, line_tx_command_reg};
            REG_LINE_RX_STA: rd_mux = {26'h0, chg_flag_r, rx_sta};
            REG_FSM_STA: rd_mux = {13'h0, state_r, 4'h0, ind_r};
            default: rd_ok = 1'b0;
        endcase
    end
    assign rd_sta_clr = ar_take && rd_off == REG_LINE_RX_STA;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_mux;
            rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
endmodule // l1a_core

// ### sim/l1a_core_props.sv
// Port-level checks of the layer-1 activation block
`timescale 1ns/1ps
module l1a_core_props
    import l1a_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic frame_tick,
    input wire logic [3:0] host_cmd,
    input wire l1a_rxsta_t rx_sta,
    input wire logic [7:0] b_line_data,
    input wire logic [3:0] host_ind,
    input wire logic [2:0] tx_info,
    input wire logic loop_en,
    input wire logic [7:0] b_host_data,
    input wire logic rx_status_change_irq,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_b_idle;
        b_host_data != B_IDLE |-> b_host_data == $past(b_line_data);
    endproperty
    a_b_idle: assert property (p_b_idle) else $error("B data not from line");
    property p_reinit;
        host_cmd == FSM_REINIT_CMD [*2] |=> !loop_en;
    endproperty
    a_reinit: assert property (p_reinit) else $error("loop kept on restart");
    property p_ind_tick;
        !$past(frame_tick) && $past(aresetn) |-> $stable(host_ind);
    endproperty
    a_ind_tick: assert property (p_ind_tick) else $error("indication moved off frame");
    property p_sbit;
        frame_tick && !rx_sta.sbit |=> host_ind != REMOTE_LOOP_SYNC_IND && host_ind != REMOTE_LOOP_ACTIVE_IND;
    endproperty
    a_sbit: assert property (p_sbit) else $error("remote loop code with S-bit 0");
    property p_irq_clr;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == REG_LINE_RX_STA && $stable(rx_sta) ##1 $stable(rx_sta) [*2]
            |=> !rx_status_change_irq;
    endproperty
    a_irq_clr: assert property (p_irq_clr) else $error("status read kept irq");
    property p_test;
        frame_tick && host_cmd == SINGLE_PULSE_CMD && host_ind == TEST_MODE_ACK_IND |=> ##1 tx_info == TX_IT2;
    endproperty
    a_test: assert property (p_test) else $error("single pulses not sent");
    property p_deact;
        frame_tick && host_cmd == DEACTIVATE_CMD |=> ##1 tx_info == TX_I0 && !loop_en;
    endproperty
    a_deact: assert property (p_deact) else $error("line not idle on deactivate");
    property p_loop;
        frame_tick && host_cmd == LOCAL_LOOP_REQUEST_CODE && host_ind == DEACTIVATION_CONFIRM_IND |=> ##1 loop_en;
    endproperty
    a_loop: assert property (p_loop) else $error("loop not closed");
endmodule // l1a_core_props

// ### sim/l1a_line_model.sv
// Line card partner: frame ticks and receive status
`timescale 1ns/1ps
module l1a_line_model
    import l1a_pkg::*;
#(
    parameter int FRAME = 8
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [2:0] tx_info,
    input wire logic loop_en,
    input wire logic go,
    input wire logic i4_ok,
    input wire logic sbit,
    output logic frame_tick,
    output l1a_rxsta_t rx_sta
);
    // ****************************************
    // Far end answer
    // ****************************************
    logic [7:0] cnt_r;
    logic [1:0] seen_r;
    wire logic sig = loop_en ? (tx_info != TX_I0) : go;
    wire logic heard = loop_en ? (tx_info == TX_I3) : (tx_info == TX_I1 || tx_info == TX_I3);
    wire logic [1:0] info = !sig ? RX_I0 : ((heard && i4_ok) ? RX_I4 : RX_I2);
    initial begin
        frame_tick = 1'h0;
        rx_sta = '0;
        cnt_r = 8'h00;
        seen_r = 2'h0;
    end
    always @(posedge aclk) begin
        cnt_r <= (!aresetn || cnt_r == FRAME - 1) ? 8'h00 : cnt_r + 8'h01;
        frame_tick <= aresetn && cnt_r == FRAME - 1;
        if (!sig) begin
            seen_r <= 2'h0;
        end else if (frame_tick && seen_r != 2'h2) begin
            seen_r <= seen_r + 2'h1;
        end
        rx_sta <= '{level: sig, sbit: sbit && !loop_en, sync: seen_r == 2'h2, info: info};
    end
endmodule // l1a_line_model

// ### sim/l1a_core_tb.sv
// Self-checking bench of the layer-1 activation block
`timescale 1ns/1ps
module l1a_core_tb
    import l1a_pkg::*;
;
    // ****************************************
    // Signals and instances
    // ****************************************
    logic aclk = 1'h0, aresetn = 1'h0, rst_pin_n = 1'h1, go = 1'h0, i4_ok = 1'h0, sbit = 1'h0;
    logic [3:0] host_cmd = CLOCK_REQUEST_CMD;
    logic [7:0] b_line_data = 8'h5a, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic frame_tick, loop_en, host_power_down, rx_status_change_irq;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    l1a_rxsta_t rx_sta;
    logic [3:0] host_ind;
    logic [2:0] tx_info;
    logic [7:0] b_host_data;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    int err_total = 0, checks = 0;
    always #5 aclk = ~aclk;
    l1a_core l1a_core_inst (.aclk, .aresetn, .rst_pin_n, .frame_tick, .host_cmd, .rx_sta, .b_line_data, .host_ind,
        .tx_info, .loop_en, .host_power_down, .b_host_data, .rx_status_change_irq, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    l1a_line_model l1a_line_model_inst (.aclk, .aresetn, .tx_info, .loop_en, .go, .i4_ok, .sbit, .frame_tick, .rx_sta);
    // ****************************************
    // Tasks
    // ****************************************
    task summarize();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task guard(input int n);
        if (n >= 100) begin
            err_total++;
            summarize();
        end
    endtask
    task cmd(input logic [3:0] c);
        @(posedge aclk);
        host_cmd <= c;
    endtask
    task frames(input int k);
        int n;
        n = 0;
        repeat (k) begin
            do begin
                @(posedge aclk);
                n++;
            end while (!frame_tick && n < 100);
        end
        guard(n);
    endtask
    task wait_ind(input logic [3:0] e);
        int n;
        n = 0;
        while (host_ind !== e && n < 100) begin
            @(posedge aclk);
            n++;
        end
        cmp("host_ind", e, host_ind);
        guard(n);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!(s_axi_bvalid && s_axi_bready) && n < 100);
        s_axi_bready <= 1'h0;
        guard(n);
        cmp("bresp", er, s_axi_bresp);
    endtask
    task rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!(s_axi_rvalid && s_axi_rready) && n < 100);
        s_axi_rready <= 1'h0;
        guard(n);
        cmp(nm, e, s_axi_rdata & m);
        cmp("rresp", er, s_axi_rresp);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task t_reset();
        rdc("fsm_sta", REG_FSM_STA, 32'h7ff0f, 32'h100, RESP_OKAY);
        rdc("conf", REG_CONF, 32'h7, {29'h0, CONF_RESET}, RESP_OKAY);
        rdc("unmapped", 8'h14, 32'hffffffff, 32'h0, RESP_SLVERR);
        wr(8'h14, 32'h0, RESP_SLVERR);
        cmd(ACTIVATE_REQUEST_CODE);
        frames(3);
        cmp("host_ind", DEACT_REQUEST_IND, host_ind);
        cmp("tx_info", TX_I0, tx_info);
        cmd(DEACTIVATE_CMD);
        wait_ind(DEACTIVATION_CONFIRM_IND);
    endtask
    task t_act();
        cmd(CLOCK_REQUEST_CMD);
        wait_ind(POWERED_UP_IND);
        cmp("tx_info", TX_I0, tx_info);
        cmd(ACTIVATE_REQUEST_CODE);
        frames(3);
        cmp("tx_info", TX_I1W, tx_info);
        go <= 1'h1;
        sbit <= 1'h1;
        wait_ind(RECEIVER_UNSYNC_IND);
        wait_ind(REMOTE_LOOP_SYNC_IND);
        cmp("tx_info", TX_I1, tx_info);
        i4_ok <= 1'h1;
        wait_ind(REMOTE_LOOP_ACTIVE_IND);
        sbit <= 1'h0;
        wait_ind(ACTIVE_IND);
        cmp("tx_info", TX_I3, tx_info);
        b_line_data <= 8'h3c;
        frames(1);
        cmp("b_host_data", 8'h3c, b_host_data);
        go <= 1'h0;
        i4_ok <= 1'h0;
        wait_ind(DEACT_REQUEST_IND);
        wr(REG_CONF, 32'h2, RESP_OKAY);
        cmd(DEACTIVATE_CMD);
        wait_ind(DEACTIVATION_CONFIRM_IND);
        cmp("power_down", 1'h1, host_power_down);
        cmp("b_host_data", B_IDLE, b_host_data);
        wr(REG_CONF, 32'h0, RESP_OKAY);
    endtask
    task t_loop();
        cmd(LOCAL_LOOP_REQUEST_CODE);
        wait_ind(RECEIVER_UNSYNC_IND);
        cmp("loop_en", 1'h1, loop_en);
        cmp("tx_info", TX_I1, tx_info);
        wait_ind(LOCAL_LOOP_REQUEST_CODE);
        cmp("tx_info", TX_I3, tx_info);
        i4_ok <= 1'h1;
        wait_ind(LOCAL_LOOP_ACTIVE_IND);
        cmp("b_host_data", B_IDLE, b_host_data);
        i4_ok <= 1'h0;
        cmd(DEACTIVATE_CMD);
        wait_ind(DEACTIVATION_CONFIRM_IND);
        cmp("loop_en", 1'h0, loop_en);
    endtask
    task t_test();
        cmd(SINGLE_PULSE_CMD);
        wait_ind(TEST_MODE_ACK_IND);
        frames(1);
        cmp("tx_info", TX_IT2, tx_info);
        cmd(CONTINUOUS_PULSE_CMD);
        frames(2);
        cmp("tx_info", TX_IT1, tx_info);
        cmd(DEACTIVATE_CMD);
        wait_ind(DEACTIVATION_CONFIRM_IND);
    endtask
    task t_restart();
        cmd(FSM_REINIT_CMD);
        wait_ind(DEACT_REQUEST_IND);
        cmp("tx_info", TX_I0, tx_info);
        cmd(DEACTIVATE_CMD);
        wait_ind(DEACTIVATION_CONFIRM_IND);
        wr(REG_SW_CLEAR, 32'h1, RESP_OKAY);
        wait_ind(DEACT_REQUEST_IND);
        rdc("sw_clear", REG_SW_CLEAR, 32'h1, 32'h0, RESP_OKAY);
        frames(2);
        wait_ind(DEACTIVATION_CONFIRM_IND);
        rst_pin_n <= 1'h0;
        repeat (4) @(posedge aclk);
        rst_pin_n <= 1'h1;
        wait_ind(DEACT_REQUEST_IND);
        wait_ind(DEACTIVATION_CONFIRM_IND);
    endtask
    task t_sw();
        cmd(CLOCK_REQUEST_CMD);
        wr(REG_CONF, 32'h1, RESP_OKAY);
        wr(REG_LINE_TX_CMD, {29'h0, TX_I1W}, RESP_OKAY);
        frames(1);
        cmp("tx_info", TX_I1W, tx_info);
        go <= 1'h1;
        frames(3);
        cmp("irq", 1'h1, rx_status_change_irq);
        rdc("rx_sta", REG_LINE_RX_STA, 32'h3f, 32'h35, RESP_OKAY);
        frames(1);
        cmp("irq", 1'h0, rx_status_change_irq);
        wr(REG_LINE_TX_CMD, {29'h0, TX_I1}, RESP_OKAY);
        frames(1);
        cmp("tx_info", TX_I1, tx_info);
        wr(REG_CONF, 32'h5, RESP_OKAY);
        go <= 1'h0;
        frames(2);
        cmp("irq", 1'h0, rx_status_change_irq);
    endtask
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        t_reset();
        t_act();
        t_loop();
        t_test();
        t_restart();
        t_sw();
        summarize();
    end
endmodule // l1a_core_tb
bind l1a_core l1a_core_props l1a_core_props_inst (.aclk, .aresetn, .frame_tick, .host_cmd, .rx_sta, .b_line_data,
    .host_ind, .tx_info, .loop_en, .b_host_data, .rx_status_change_irq, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready);
